/* shared/slw_pkg.sv */
// sleep/wake controller constants: register map, reset values, timing
// assumes a 100 MHz pclk; all timers run on a 1 ms tick
package slw_pkg;
	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SP_UNIT_MS = 10;
	localparam int CHECK_MS = 2;
	localparam int UNICAST_MS = 20;
	localparam int MIN_WAKE_MS = 10;
	localparam int HOP_MS = 5;
	// ***************************************************************
	// register byte offsets
	// ***************************************************************
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_OPT = 8'h04;
	localparam logic [7:0] ADDR_SN = 8'h08;
	localparam logic [7:0] ADDR_SP = 8'h0C;
	localparam logic [7:0] ADDR_ST = 8'h10;
	localparam logic [7:0] ADDR_WH = 8'h14;
	localparam logic [7:0] ADDR_NET = 8'h18;
	localparam logic [7:0] ADDR_STAT = 8'h1C;
	localparam logic [7:0] ADDR_HOLD = 8'h20;
	// ***************************************************************
	// reset values and limits
	// ***************************************************************
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [10:0] OPT_RST = 11'h002;
	localparam logic [10:0] OPT_MASK = 11'h53F;
	localparam logic [15:0] SN_RST = 16'h0001;
	localparam logic [21:0] SP_RST = 22'h000190;
	localparam logic [21:0] SP_MAX = 22'h15F900;
	localparam logic [21:0] ST_RST = 22'h001F40;
	localparam logic [21:0] ST_MAX = 22'h36EE80;
	localparam logic [15:0] WH_RST = 16'h0000;
	localparam logic [7:0] MT_RST = 8'h01;
	localparam logic [7:0] NH_RST = 8'h07;
	localparam logic [7:0] NN_RST = 8'h03;
	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int OPT_PREF_COORD = 0;
	localparam int OPT_NON_COORD = 1;
	localparam int OPT_STATUS_MSG = 2;
	localparam int OPT_NO_EARLY = 3;
	localparam int OPT_EQUAL = 4;
	localparam int OPT_NO_RAPID = 5;
	localparam int OPT_FULL_WAKE = 8;
	localparam int OPT_RAND_IO = 10;
	localparam int NET_MT_LSB = 0;
	localparam int NET_NH_LSB = 8;
	localparam int NET_NN_LSB = 16;
	// ***************************************************************
	// sleep mode codes and states
	// ***************************************************************
	localparam logic [3:0] MODE_AWAKE = 4'h0;
	localparam logic [3:0] MODE_PIN = 4'h1;
	localparam logic [3:0] MODE_ACYC = 4'h4;
	localparam logic [3:0] MODE_ACYC_PIN = 4'h5;
	localparam logic [3:0] MODE_SUPPORT = 4'h7;
	localparam logic [3:0] MODE_SYNC = 4'h8;
	typedef enum logic [1:0] {S_AWAKE, S_SLEEP, S_CHECK} slw_state_t;
endpackage : slw_pkg

/* logic/slw_tick.sv */
// millisecond tick divider for the sleep/wake controller
// assumes one clock; the tick is a one-cycle enable pulse
`timescale 1ns/10ps
module slw_tick
#(
	parameter int CYC = 100000
)
(
	// clock and reset
	input logic pclk,
	input logic presetn,
	// tick out
	output logic tick_q
);
	logic [31:0] cnt_q;
	generate
		if (CYC < 2)
		begin : g_chk
			$error("slw_tick: CYC must be at least 2");
		end
	endgenerate
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end
		else if (cnt_q == 32'(CYC - 1))
		begin
			cnt_q <= 32'h00000000;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end
endmodule : slw_tick

/* logic/slw_ctrl.sv */
// sleep/wake sequencer with APB register file
// assumes pins synchronous to pclk; host_char and rf_data are pulses
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module slw_ctrl
	import slw_pkg::*;
#(
	parameter int TICK_CYC_P = TICK_CYC
)
(
	// clock and reset
	input logic pclk,
	input logic presetn,
	// apb slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host and radio events
	input logic sleep_req,
	input logic host_char,
	input logic rf_data,
	// status outputs
	output logic radio_on_q,
	output logic on_sleep_q,
	output logic host_ready_q,
	output logic coord_q,
	output logic pulse_out_q,
	output logic [4:0] net_flags_q
);
	// ***************************************************************
	// registers and state
	// ***************************************************************
	logic [3:0] mode_q, mode_prv_q;
	logic [10:0] opt_q;
	logic [15:0] sn_q, wh_q, whd_q, cnt_q, cnt_d;
	logic [21:0] sp_q, st_q;
	logic [7:0] mt_q, nh_q, nn_q;
	logic [25:0] tmr_q, tmr_d;
	slw_state_t state_q, state_d;
	logic ind_d, pls_d, sreq_q;
	logic [31:0] prdata_q, rd_d;
	logic pready_q, pslverr_q, err_d;
	logic tick;

	slw_tick #(.CYC(TICK_CYC_P)) u_tick
	(
		.pclk(pclk),
		.presetn(presetn),
		.tick_q(tick)
	);

	// ***************************************************************
	// derived timing
	// ***************************************************************
	wire chg = mode_q != mode_prv_q;
	wire is_async = (mode_q == MODE_ACYC) || (mode_q == MODE_ACYC_PIN);
	wire is_sync = (mode_q == MODE_SUPPORT) || (mode_q == MODE_SYNC);
	wire data = host_char || rf_data;
	wire sreq_fall = sreq_q && !sleep_req;
	wire expire = tick && (tmr_q == 26'h0000000);
	wire [25:0] sp_ms = 26'(sp_q) * 26'(SP_UNIT_MS);
	wire [25:0] st_ms = 26'(st_q);
	wire [25:0] wh_ms = 26'(wh_q);
	// sleep trimmed by host delay so the host is ready at network wake
	wire [25:0] sync_sleep = (sp_ms > wh_ms) ? sp_ms - wh_ms : '0;
	wire [25:0] wh_plus = wh_ms + 26'(UNICAST_MS);
	wire [25:0] sync_wake = (st_ms > wh_plus) ? st_ms : wh_plus;
	wire [21:0] min_wake = 22'(MIN_WAKE_MS)
		+ (22'(mt_q) + 22'h000001) * 22'(nh_q) * 22'(HOP_MS)
		+ 22'(nn_q) * 22'(HOP_MS);
	wire [16:0] cnt_nx = {1'b0, cnt_q} + 17'h00001;
	wire [24:0] hold = 25'((26'(sp_q) * 26'h0000005) >> 1);
	wire is_code_async = (pwdata[3:0] == MODE_ACYC)
		|| (pwdata[3:0] == MODE_ACYC_PIN);
	wire is_code_sync = (pwdata[3:0] == MODE_SUPPORT)
		|| (pwdata[3:0] == MODE_SYNC);
	wire mode_ok = (pwdata[3:0] == MODE_AWAKE) || (pwdata[3:0] == MODE_PIN)
		|| is_code_async || is_code_sync;
	wire setup = psel && !penable;
	wire wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

	// ***************************************************************
	// sequencer next state
	// ***************************************************************
	always_comb
	begin
		state_d = state_q;
		tmr_d = tmr_q;
		cnt_d = cnt_q;
		ind_d = on_sleep_q;
		pls_d = 1'b0;
		if (tick && (tmr_q != 26'h0000000))
			tmr_d = tmr_q - 26'h0000001;
		if (chg)
		begin
			state_d = S_AWAKE;
			tmr_d = is_sync ? sync_wake : st_ms;
			cnt_d = '0;
			ind_d = 1'b1;
		end
		else if (mode_q == MODE_PIN)
		begin
			state_d = sleep_req ? S_SLEEP : S_AWAKE;
			ind_d = !sleep_req;
		end
		else if (is_async)
		begin
			case (state_q)
				S_AWAKE:
					if (data)
						tmr_d = st_ms;
					else if (expire && (sp_ms != 26'h0000000))
					begin
						state_d = S_SLEEP;
						tmr_d = sp_ms;
						ind_d = 1'b0;
					end
				S_SLEEP:
					if ((mode_q == MODE_ACYC_PIN) && sreq_fall)
					begin
						state_d = S_AWAKE;
						tmr_d = st_ms;
						cnt_d = '0;
						ind_d = 1'b1;
					end
					else if (expire && (cnt_nx >= {1'b0, sn_q}))
					begin
						state_d = S_AWAKE;
						tmr_d = st_ms;
						cnt_d = '0;
						ind_d = 1'b1;
					end
					else if (expire)
					begin
						state_d = S_CHECK;
						tmr_d = 26'(CHECK_MS);
						cnt_d = cnt_nx[15:0];
					end
				S_CHECK:
					if (data)
					begin
						state_d = S_AWAKE;
						tmr_d = st_ms;
						cnt_d = '0;
						ind_d = 1'b1;
					end
					else if (expire)
					begin
						state_d = S_SLEEP;
						tmr_d = sp_ms;
					end
				default:
					state_d = S_AWAKE;
			endcase
		end
		else if (is_sync)
		begin
			// period count plays no part here
			case (state_q)
				S_AWAKE:
					if (sp_ms == 26'h0000000)
					begin
						if (expire)
						begin
							tmr_d = sync_wake;
							pls_d = 1'b1;
						end
					end
					else if (expire
						|| (sleep_req && !opt_q[OPT_FULL_WAKE]))
					begin
						state_d = S_SLEEP;
						tmr_d = sync_sleep;
						ind_d = 1'b0;
					end
				S_SLEEP:
					if (expire)
					begin
						state_d = S_AWAKE;
						tmr_d = sync_wake;
						ind_d = 1'b1;
						pls_d = 1'b1;
					end
				default:
					state_d = S_AWAKE;
			endcase
		end
		else
		begin
			state_d = S_AWAKE;
			ind_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= S_AWAKE;
			tmr_q <= '0;
			cnt_q <= '0;
			on_sleep_q <= 1'b1;
			pulse_out_q <= 1'b0;
			radio_on_q <= 1'b1;
			sreq_q <= 1'b0;
			mode_prv_q <= MODE_RST;
		end
		else
		begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			cnt_q <= cnt_d;
			on_sleep_q <= ind_d;
			pulse_out_q <= pls_d;
			radio_on_q <= state_d != S_SLEEP;
			sreq_q <= sleep_req;
			mode_prv_q <= mode_q;
		end
	end

	// ***************************************************************
	// wake-host delay and role
	// ***************************************************************
	// reloaded all through sleep so every wake starts a fresh delay
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			whd_q <= '0;
			host_ready_q <= 1'b0;
			coord_q <= 1'b0;
			net_flags_q <= '0;
		end
		else
		begin
			if (state_q != S_AWAKE)
				whd_q <= wh_q;
			else if (host_char)
				whd_q <= '0;
			else if (tick && (whd_q != 16'h0000))
				whd_q <= whd_q - 16'h0001;
			host_ready_q <= (state_q == S_AWAKE) && (whd_q == 16'h0000);
			coord_q <= is_sync && opt_q[OPT_PREF_COORD]
				&& !opt_q[OPT_NON_COORD];
			net_flags_q <= {opt_q[OPT_RAND_IO], opt_q[OPT_NO_RAPID],
				opt_q[OPT_EQUAL], opt_q[OPT_NO_EARLY],
				opt_q[OPT_STATUS_MSG]};
		end
	end

	// ***************************************************************
	// apb decode
	// ***************************************************************
	always_comb
	begin
		rd_d = '0;
		err_d = 1'b0;
		if (paddr == ADDR_MODE)
		begin
			rd_d = 32'(mode_q);
			err_d = pwrite && !mode_ok;
		end
		else if (paddr == ADDR_OPT)
		begin
			rd_d = 32'(opt_q);
			err_d = pwrite && ((pwdata[1:0] == 2'h3)
				|| ((pwdata & ~32'(OPT_MASK)) != 32'h00000000));
		end
		else if (paddr == ADDR_SN)
		begin
			rd_d = 32'(sn_q);
			err_d = pwrite && ((pwdata[15:0] == 16'h0000)
				|| (pwdata[31:16] != 16'h0000));
		end
		else if (paddr == ADDR_SP)
		begin
			rd_d = 32'(sp_q);
			err_d = pwrite && (pwdata > 32'(SP_MAX));
		end
		else if (paddr == ADDR_ST)
		begin
			rd_d = 32'(st_q);
			err_d = pwrite && ((pwdata == 32'h00000000)
				|| (pwdata > 32'(ST_MAX)));
		end
		else if (paddr == ADDR_WH)
		begin
			rd_d = 32'(wh_q);
			err_d = pwrite && (pwdata[31:16] != 16'h0000);
		end
		else if (paddr == ADDR_NET)
			rd_d = {8'h00, nn_q, nh_q, mt_q};
		else if (paddr == ADDR_STAT)
		begin
			rd_d = {26'h0000000, state_q, coord_q, host_ready_q,
				on_sleep_q, radio_on_q};
			err_d = pwrite;
		end
		else if (paddr == ADDR_HOLD)
		begin
			rd_d = 32'(hold);
			err_d = pwrite;
		end
		else
			err_d = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end
		else
		begin
			pready_q <= setup;
			pslverr_q <= setup && err_d;
			prdata_q <= (setup && !pwrite) ? rd_d : '0;
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	// ***************************************************************
	// register file
	// ***************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q <= MODE_RST;
			opt_q <= OPT_RST;
			sn_q <= SN_RST;
			sp_q <= SP_RST;
			st_q <= ST_RST;
			wh_q <= WH_RST;
			mt_q <= MT_RST;
			nh_q <= NH_RST;
			nn_q <= NN_RST;
		end
		else if (wr_en)
		begin
			if (paddr == ADDR_MODE)
				mode_q <= pwdata[3:0];
			else if (paddr == ADDR_OPT)
				opt_q <= pwdata[10:0];
			else if (paddr == ADDR_SN)
				sn_q <= pwdata[15:0];
			else if (paddr == ADDR_SP)
				sp_q <= pwdata[21:0];
			else if (paddr == ADDR_ST)
				st_q <= pwdata[21:0];
			else if (paddr == ADDR_WH)
				wh_q <= pwdata[15:0];
			else if (paddr == ADDR_NET)
			begin
				mt_q <= pwdata[NET_MT_LSB +: 8];
				nh_q <= pwdata[NET_NH_LSB +: 8];
				nn_q <= pwdata[NET_NN_LSB +: 8];
			end
		end
		else if (is_sync && (st_q < min_wake))
			st_q <= min_wake;
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_bad_opt;
		psel && penable && pready && pwrite && (paddr == ADDR_OPT)
			&& (pwdata[1:0] == 2'h3);
	endsequence
	sequence s_char_awake;
		host_char && (state_q == S_AWAKE) && (state_d == S_AWAKE);
	endsequence

	property p_mode0_awake;
		(mode_q == MODE_AWAKE) [*2] |-> (state_q == S_AWAKE) && radio_on_q;
	endproperty
	a_mode0_awake: assert property (p_mode0_awake)
		else $error("mode 0 not awake");
	property p_pin_sleep;
		(mode_q == MODE_PIN) && !chg && sleep_req |=> !radio_on_q;
	endproperty
	a_pin_sleep: assert property (p_pin_sleep)
		else $error("pin sleep not followed");
	property p_async_sleep;
		is_async && !chg && (state_q == S_AWAKE) && expire && !data
			&& (sp_ms != 0) |=> (state_q == S_SLEEP)
			&& (tmr_q == $past(sp_ms)) && !on_sleep_q;
	endproperty
	a_async_sleep: assert property (p_async_sleep)
		else $error("async sleep entry wrong");
	property p_pin_wake;
		(mode_q == MODE_ACYC_PIN) && !chg && (state_q == S_SLEEP)
			&& sreq_fall |=> (state_q == S_AWAKE) && on_sleep_q;
	endproperty
	a_pin_wake: assert property (p_pin_wake)
		else $error("falling edge did not wake");
	property p_bad_opt;
		s_bad_opt |-> pslverr ##1 (opt_q == $past(opt_q));
	endproperty
	a_bad_opt: assert property (p_bad_opt)
		else $error("conflicting options taken");
	property p_no_coord;
		opt_q[OPT_NON_COORD] [*2] |-> !coord_q;
	endproperty
	a_no_coord: assert property (p_no_coord)
		else $error("coordinator despite bit 1");
	property p_pref_coord;
		is_sync && opt_q[OPT_PREF_COORD] && !opt_q[OPT_NON_COORD] |=> coord_q;
	endproperty
	a_pref_coord: assert property (p_pref_coord)
		else $error("bit 0 did not make coordinator");
	property p_check;
		is_async && !chg && (state_q == S_SLEEP) && expire && !sreq_fall
			&& (cnt_nx < {1'b0, sn_q}) |=> (state_q == S_CHECK) && !on_sleep_q
			##1 (tmr_q <= 26'(CHECK_MS));
	endproperty
	a_check: assert property (p_check)
		else $error("check cycle wrong");
	property p_check_data;
		is_async && !chg && (state_q == S_CHECK) && data
			|=> (state_q == S_AWAKE) && on_sleep_q;
	endproperty
	a_check_data: assert property (p_check_data)
		else $error("data in check did not wake");
	property p_wh_stop;
		s_char_awake |=> (whd_q == 16'h0000) ##1 host_ready_q;
	endproperty
	a_wh_stop: assert property (p_wh_stop)
		else $error("host char did not stop delay");
	property p_sync_sleep;
		is_sync && !chg && (state_q == S_AWAKE) && expire && (sp_ms != 0)
			|=> (state_q == S_SLEEP) && (tmr_q == $past(sync_sleep));
	endproperty
	a_sync_sleep: assert property (p_sync_sleep)
		else $error("sync sleep length wrong");
endmodule : slw_ctrl

/* test/slw_host.sv */
// host model: drives the sleep request pin and serial character strobes
// assumes the bench calls its tasks just after a rising pclk edge
`timescale 1ns/10ps
module slw_host
(
	// clock
	input wire logic pclk,
	// pins toward the device
	output logic sleep_req,
	output logic host_char
);
	initial
	begin
		sleep_req = 1'b0;
		host_char = 1'b0;
	end

	task automatic set_sleep(input logic v);
		@(posedge pclk);
		sleep_req <= v;
	endtask : set_sleep

	// a character is a single-cycle strobe, the device must drop its delay
	task automatic send_char();
		@(posedge pclk);
		host_char <= 1'b1;
		@(posedge pclk);
		host_char <= 1'b0;
	endtask : send_char
endmodule : slw_host

/* test/slw_ctrl_tb.sv */
// testbench for the sleep/wake controller: apb master, host model, pins
// assumes a 10 cycle millisecond tick so that sleep cycles stay short
`timescale 1ns/10ps
module slw_ctrl_tb;
	import slw_pkg::*;
	localparam int TCYC = 10;
	localparam int CEIL = 20000;
	localparam logic [32:0] OK = 33'h0_0000_0000;
	localparam logic [32:0] BAD = 33'h1_0000_0000;
	localparam int MINW = MIN_WAKE_MS + (int'(MT_RST) + 1) * int'(NH_RST)
		* HOP_MS + int'(NN_RST) * HOP_MS;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic rf_data = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, radio_on_q, on_sleep_q, host_ready_q, coord_q;
	logic pulse_out_q;
	logic [4:0] net_flags_q;
	wire sleep_req, host_char;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	logic [31:0] r;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 32'h21A3;
	int n;

	always #5 pclk = ~pclk;

	slw_host host_u (.pclk(pclk), .sleep_req(sleep_req),
		.host_char(host_char));

	slw_ctrl #(.TICK_CYC_P(TCYC)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_req(sleep_req), .host_char(host_char),
		.rf_data(rf_data), .radio_on_q(radio_on_q),
		.on_sleep_q(on_sleep_q), .host_ready_q(host_ready_q),
		.coord_q(coord_q), .pulse_out_q(pulse_out_q),
		.net_flags_q(net_flags_q));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		n_tests++;
		if (seen !== want)
		begin
			err_total++;
			$display("MISMATCH at %0t seen %0h expected %0h", $time, seen,
				want);
		end
	endtask : check

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	// no release at the end, so a following transfer may go back to back
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] want);
		exp_q.push_back(want);
		msk_q.push_back(wr ? 33'h1_0000_0000 : 33'h1_FFFF_FFFF);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
	endtask : apb

	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : idle

	function automatic logic pick(input int s);
		case (s)
			0: return radio_on_q;
			1: return host_ready_q;
			2: return pulse_out_q;
			default: return coord_q;
		endcase
	endfunction : pick

	// status is looked at on the falling edge, where it has settled
	task automatic await(input int s, input logic v, input int lim);
		n = 0;
		@(negedge pclk);
		while (pick(s) !== v && n < lim)
		begin
			@(negedge pclk);
			n++;
		end
		check({32'h0, pick(s)}, {32'h0, v});
		@(posedge pclk);
	endtask : await

	task automatic hold(input int s, input logic v, input int len);
		int bad;
		bad = 0;
		repeat (len)
		begin
			@(negedge pclk);
			if (pick(s) !== v)
				bad++;
		end
		check(33'(bad), 33'h0);
		@(posedge pclk);
	endtask : hold

	// ****************************************
	// result watcher and timeout
	// ****************************************
	always @(posedge pclk)
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
			check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == CEIL)
		begin
			err_total++;
			report_and_stop();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_MODE, 32'h0, {29'h0, MODE_RST});
		apb(1'b0, ADDR_OPT, 32'h0, {22'h0, OPT_RST});
		apb(1'b0, ADDR_SN, 32'h0, {17'h0, SN_RST});
		apb(1'b0, ADDR_SP, 32'h0, {11'h0, SP_RST});
		apb(1'b0, ADDR_ST, 32'h0, {11'h0, ST_RST});
		apb(1'b0, ADDR_WH, 32'h0, {17'h0, WH_RST});
		apb(1'b0, ADDR_NET, 32'h0, {9'h0, NN_RST, NH_RST, MT_RST});
		apb(1'b0, ADDR_STAT, 32'h0, 33'h7);
		apb(1'b0, ADDR_HOLD, 32'h0, 33'(int'(SP_RST) * 5 / 2));
		apb(1'b0, 8'h24, 32'h0, BAD);
		apb(1'b1, ADDR_STAT, 32'h1, BAD);
		apb(1'b1, ADDR_OPT, 32'h3, BAD);
		apb(1'b1, ADDR_OPT, 32'h80, BAD);
		apb(1'b1, ADDR_SN, 32'h0, BAD);
		apb(1'b1, ADDR_SN, 32'h10000, BAD);
		apb(1'b1, ADDR_SP, {10'h0, SP_MAX} + 32'h1, BAD);
		apb(1'b1, ADDR_ST, 32'h0, BAD);
		apb(1'b1, ADDR_ST, {10'h0, ST_MAX} + 32'h1, BAD);
		apb(1'b1, ADDR_WH, 32'h10000, BAD);
		for (int i = 0; i < 16; i++)
			if (!(i inside {0, 1, 4, 5, 7, 8}))
				apb(1'b1, ADDR_MODE, 32'(i), BAD);
		apb(1'b1, ADDR_SP, {10'h0, SP_MAX}, OK);
		apb(1'b0, ADDR_HOLD, 32'h0, 33'(int'(SP_MAX) * 5 / 2));
		apb(1'b1, ADDR_ST, {10'h0, ST_MAX}, OK);
		apb(1'b0, ADDR_ST, 32'h0, {11'h0, ST_MAX});
		repeat (3)
		begin
			r = $random(seed) & 32'h0000FFFF | 32'h1;
			apb(1'b1, ADDR_SN, r, OK);
			apb(1'b0, ADDR_SN, 32'h0, {1'b0, r});
		end
		apb(1'b1, ADDR_SP, 32'h1, OK);
		apb(1'b1, ADDR_ST, 32'h1, OK);
		apb(1'b1, ADDR_SN, 32'h2, OK);
		apb(1'b1, ADDR_WH, 32'h5, OK);
		idle();
		// pin sleep: ignored in mode 0, followed in mode 1
		host_u.set_sleep(1'b1);
		hold(0, 1'b1, 20);
		apb(1'b1, ADDR_MODE, 32'h1, OK);
		idle();
		await(0, 1'b0, 5);
		host_u.set_sleep(1'b0);
		await(0, 1'b1, 5);
		hold(1, 1'b0, 40);
		await(1, 1'b1, 40);
		host_u.set_sleep(1'b1);
		await(0, 1'b0, 5);
		// async cycling, entered while asleep
		apb(1'b1, ADDR_MODE, 32'h4, OK);
		idle();
		await(0, 1'b1, 3);
		await(0, 1'b0, 40);
		await(0, 1'b1, 130);
		apb(1'b0, ADDR_STAT, 32'h0, 33'h21);
		idle();
		await(0, 1'b0, 40);
		await(0, 1'b1, 130);
		apb(1'b0, ADDR_STAT, 32'h0, 33'h03);
		idle();
		repeat (6)
		begin
			rf_data <= 1'b1;
			@(posedge pclk);
			rf_data <= 1'b0;
			hold(0, 1'b1, 9);
		end
		await(0, 1'b0, 40);
		// falling pin edge cuts a sleep short
		apb(1'b1, ADDR_MODE, 32'h5, OK);
		idle();
		await(0, 1'b1, 3);
		await(0, 1'b0, 40);
		host_u.set_sleep(1'b0);
		await(0, 1'b1, 4);
		// wake lasts one to two ticks here, so the char must come early
		hold(1, 1'b0, 5);
		host_u.send_char();
		await(1, 1'b1, 4);
		// synchronous modes
		apb(1'b1, ADDR_OPT, 32'h1, OK);
		apb(1'b1, ADDR_MODE, 32'h8, OK);
		apb(1'b1, ADDR_ST, 32'h1, OK);
		// the raise lands one cycle after the write
		idle();
		@(posedge pclk);
		apb(1'b0, ADDR_ST, 32'h0, 33'(MINW));
		idle();
		await(3, 1'b1, 3);
		apb(1'b1, ADDR_OPT, 32'h2, OK);
		idle();
		await(3, 1'b0, 3);
		apb(1'b1, ADDR_OPT, 32'h53D, OK);
		apb(1'b1, ADDR_MODE, 32'h7, OK);
		idle();
		await(3, 1'b1, 3);
		check({28'h0, net_flags_q}, 33'h1F);
		await(0, 1'b0, 1100);
		await(0, 1'b1, 80);
		check({32'h0, n < 70}, 33'h1);
		apb(1'b1, ADDR_SP, 32'h0, OK);
		idle();
		await(2, 1'b1, 1300);
		hold(0, 1'b1, 200);
		report_and_stop();
	end
endmodule : slw_ctrl_tb
